// file: core/pfb_core_end.sv
// Processor core end: software orders arrive over Avalon-MM registers.
// Assumes the device end answers through the shared interface.
`timescale 1ns/1ps
module pfb_core_end
   import pfb_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // Avalon-MM slave
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Link to the device end
   pfb_if.core              bus
);
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ARGS = 4'h1;
   localparam logic [3:0] REG_CALL = 4'h2;
   localparam logic [3:0] REG_STAT = 4'h3;

   typedef struct packed {
      logic        pend;
      logic        busy;
      logic [15:0] dp;
      logic [7:0]  acc;
      logic [15:0] call;
      logic [7:0]  acc_res;
      logic [15:0] dp_res;
      logic        done;
      logic [31:0] rdata;
      logic        ack;
   } pfb_core_type;

   pfb_core_type r;
   pfb_core_type next_r;

   // One-cycle answer; waitrequest held while a service call runs
   always_comb begin
      next_r     = r;
      next_r.ack = 1'b0;
      if ((i_avs_read || i_avs_write) && !r.ack && !r.busy) begin
         next_r.ack = 1'b1;
         case (i_avs_address)
            REG_CTRL: next_r.rdata = {24'h0, bus.reg_rdata};
            REG_ARGS: next_r.rdata = {r.acc, 8'h00, r.dp};
            REG_CALL: next_r.rdata = {16'h0, r.call};
            REG_STAT: next_r.rdata = {7'h0, r.done, r.acc_res, r.dp_res};
            default:  next_r.rdata = 32'h0;
         endcase
         if (i_avs_write && i_avs_address == REG_ARGS) begin
            next_r.dp  = i_avs_writedata[15:0];
            next_r.acc = i_avs_writedata[31:24];
         end
         if (i_avs_write && i_avs_address == REG_CALL) begin
            next_r.call = i_avs_writedata[15:0];
            next_r.pend = 1'b1;
            next_r.done = 1'b0;
         end
      end
      // Call issues a fetch at entry, then holds until completion
      if (r.pend) begin
         next_r.pend = 1'b0;
         next_r.busy = 1'b1;
      end
      if (r.busy && bus.svc_done) begin
         next_r.busy    = 1'b0;
         next_r.done    = 1'b1;
         next_r.acc_res = bus.acc_out;
         next_r.dp_res  = bus.dp_out;
      end
      // Call that started no array cycle frees the bus at once
      if (r.busy && !bus.array_busy && !bus.svc_done)
         next_r.busy = 1'b0;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) r <= '0;
      else r <= next_r;
   end

   // Reserved bit forced low on register writes
   assign bus.reg_wr       = i_avs_write && i_avs_address == REG_CTRL && !r.ack && !r.busy;
   assign bus.reg_addr     = CTRL_ADDR;
   assign bus.reg_wdata    = i_avs_writedata[7:0] & ~(8'h01 << BIT_RSVD);
   assign bus.wr_src       = SRC_ARRAY;
   assign bus.fetch        = r.pend;
   assign bus.fetch_addr   = r.call;
   assign bus.ret          = r.busy && bus.svc_done;
   assign bus.ret_addr     = 16'h0000;
   assign bus.data_pointer = r.dp;
   assign bus.acc          = r.acc;
   assign o_avs_readdata   = r.rdata;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !r.ack;
endmodule // pfb_core_end

// file: core/pfb_device.sv
// Program memory control end: mapping, boot select, array sequencer.
// Assumes the core end drives register writes and fetch/return events.
//
// Design decision made in the core end: the Avalon-MM register port.
`timescale 1ns/1ps
module pfb_device
   import pfb_pkg::*;
#(
   parameter int PROG_CNT  = PROG_CYCLES,
   parameter int ERASE_CNT = ERASE_CYCLES
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // Reset straps, active low pins except the address latch, which is active high
   input  wire logic        i_fetch_strobe_pin_n,
   input  wire logic        i_external_access_pin_n,
   input  wire logic        i_addr_latch_pin,
   // Core side
   pfb_if.device            bus,
   // Array port
   output logic [14:0]      o_array_addr,
   output logic [7:0]       o_array_wdata,
   output logic             o_array_wr,
   output logic [14:0]      o_erase_base,
   output logic [14:0]      o_erase_mask,
   output logic             o_array_erase,
   input  wire logic [7:0]  i_array_rdata,
   // Status
   output logic             o_boot_start,
   output logic             o_internal_start
);
   typedef struct packed {
      pfb_state_type state;
      logic          bsel_high;
      logic          bsel_low;
      logic          hv;
      logic [3:0]    fcode;
      logic [31:0]   cnt;
      logic [2:0]    s_fs;
      logic [2:0]    s_ea;
      logic [2:0]    s_al;
      logic          strap_done;
      logic          boot_start;
      logic          int_start;
      logic          secure;
      logic [14:0]   addr;
      logic [7:0]    data;
      logic [7:0]    acc_out;
      logic [15:0]   dp_out;
      logic          done;
      logic          wr;
      logic          er;
      logic [14:0]   emask;
   } pfb_dev_type;

   pfb_dev_type r;
   pfb_dev_type next_r;

   // Start of an array cycle on the appropriate entry point
   function automatic logic entry_hit(input logic [15:0] a, input logic [3:0] fc);
      entry_hit = (a == ENTRY_WRITE && fc == FC_BYTE) || (a == ENTRY_PAGE && fc == FC_PAGE) ||
                  (a == ENTRY_BLOCK && fc == FC_BLOCK) || (a == ENTRY_FULL && fc == FC_FULL);
   endfunction

   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      next_r.wr   = 1'b0;
      next_r.er   = 1'b0;
      // Three-stage strap sampling, change taken when last two agree
      next_r.s_fs = {r.s_fs[1:0], i_fetch_strobe_pin_n};
      next_r.s_ea = {r.s_ea[1:0], i_external_access_pin_n};
      next_r.s_al = {r.s_al[1:0], i_addr_latch_pin};
      if (!r.strap_done && r.s_fs[2] == r.s_fs[1] && r.s_ea[2] == r.s_ea[1] && r.s_al[2] == r.s_al[1]) begin
         next_r.strap_done = 1'b1;
         if (!r.s_fs[2] && !r.s_ea[2] && r.s_al[2]) begin
            next_r.boot_start = 1'b1;
            next_r.bsel_high  = 1'b1;
            next_r.bsel_low   = 1'b1;
         end else begin
            next_r.int_start  = r.s_ea[2];
         end
      end
      // Register write: high voltage bit read-only, reserved bit dropped
      if (bus.reg_wr && bus.reg_addr == CTRL_ADDR && r.state == ST_IDLE) begin
         next_r.bsel_high = bus.reg_wdata[BIT_BSEL_HIGH];
         next_r.bsel_low  = bus.reg_wdata[BIT_BSEL_LOW];
         if (!r.secure || bus.wr_src == SRC_ARRAY || bus.reg_wdata[3:0] == FC_FULL)
            next_r.fcode = bus.reg_wdata[3:0];
      end
      // Return out of the boot area clears selection
      if (bus.ret && bus.ret_addr < BOOT_BORDER && (r.bsel_low || r.bsel_high)) begin
         next_r.bsel_high = 1'b0;
         next_r.bsel_low  = 1'b0;
      end
      if (bus.fetch && bus.fetch_addr < BOOT_BORDER && r.bsel_high && !r.bsel_low)
         next_r.bsel_high = 1'b0;
      case (r.state)
         ST_IDLE: begin
            // Only fetches from the boot area start an array cycle
            if (bus.fetch && bus.map_boot && entry_hit(bus.fetch_addr, r.fcode)) begin
               next_r.state = ST_BUSY;
               next_r.hv    = (r.fcode != FC_NONE);
               next_r.addr  = bus.data_pointer[14:0];
               next_r.data  = bus.acc;
               // Fixed counts only, software has no say in duration
               next_r.cnt   = 32'(r.fcode == FC_BYTE ? PROG_CNT : ERASE_CNT);
               next_r.emask = (r.fcode == FC_PAGE) ? PAGE_MASK :
                              (r.fcode == FC_BLOCK) ? BLOCK_MASK : 15'h0000;
               if (r.fcode == FC_BYTE) next_r.wr = 1'b1;
               else next_r.er = 1'b1;
            end
         end
         ST_BUSY: begin
            // Timer counts down once per clock cycle
            if (r.cnt == 32'h0) begin
               next_r.state = ST_DONE;
            end else begin
               next_r.cnt = r.cnt - 32'h1;
            end
         end
         ST_DONE: begin
            next_r.state     = ST_IDLE;
            next_r.done      = 1'b1;
            // Voltage flag drops with busy, so the two never disagree
            next_r.hv        = 1'b0;
            next_r.bsel_high = 1'b0;
            next_r.bsel_low  = 1'b0;
            next_r.dp_out    = {1'b0, r.addr};
            case (r.fcode)
               FC_BYTE:  next_r.acc_out = i_array_rdata;
               FC_PAGE: begin
                  next_r.acc_out       = 8'h08;
                  next_r.dp_out[4:0]   = 5'h00;
               end
               FC_BLOCK: begin
                  next_r.acc_out       = 8'h02;
                  next_r.dp_out[7:0]   = BLOCK_DP_LOW;
               end
               FC_FULL: begin
                  next_r.acc_out = 8'h0a;
                  next_r.dp_out  = {8'h00, FULL_DP_OUT};
                  next_r.secure  = 1'b0;
               end
               default: next_r.acc_out = r.data;
            endcase
         end
         default: next_r.state = ST_IDLE;
      endcase
      // Protection byte sampled while idle from the top location
      if (r.state == ST_IDLE && bus.fetch && !bus.map_boot && bus.fetch_addr[14:0] == SECURITY_ADDR)
         next_r.secure = (i_array_rdata != ERASED_BYTE);
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         r           <= '0;
         r.state     <= ST_IDLE;
         r.fcode     <= FC_NONE;
         // Straps keep shifting, levels held during reset count
         r.s_fs      <= next_r.s_fs;
         r.s_ea      <= next_r.s_ea;
         r.s_al      <= next_r.s_al;
      end else begin
         r <= next_r;
      end
   end

   // Mapping: boot ROM in top 1K when exactly one select set (01 or 10), everywhere for 11
   always_comb begin
      bus.map_boot = (r.bsel_high && r.bsel_low) ||
                     ((r.bsel_low ^ r.bsel_high) && bus.fetch_addr >= BOOT_BORDER);
   end

   // Register image and status outputs
   assign bus.reg_rdata     = {r.bsel_high, r.bsel_low, r.hv, 1'b0, r.fcode};
   assign bus.array_busy    = (r.state != ST_IDLE);
   assign bus.fetch_blocked = (r.state != ST_IDLE) && !bus.map_boot;
   assign bus.svc_done      = r.done;
   assign bus.acc_out       = r.acc_out;
   assign bus.dp_out        = r.dp_out;
   assign o_array_addr      = r.addr;
   assign o_array_wdata     = r.data;
   assign o_array_wr        = r.wr;
   assign o_array_erase     = r.er;
   assign o_erase_base      = r.addr & r.emask;
   assign o_erase_mask      = r.emask;
   assign o_boot_start      = r.boot_start;
   assign o_internal_start  = r.int_start;
endmodule // pfb_device

// file: pkg/pfb_if.sv
// Interface joining the processor core end and the memory control end.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pfb_if;
   import pfb_pkg::*;
   // Register access from the core
   logic        reg_wr;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   pfb_src_type wr_src;
   // Fetch and return tracking
   logic        fetch;
   logic [15:0] fetch_addr;
   logic        ret;
   logic [15:0] ret_addr;
   // Service call arguments
   logic [15:0] data_pointer;
   logic [7:0]  acc;
   // Mapping and progress
   logic        map_boot;
   logic        array_busy;
   logic        svc_done;
   logic [7:0]  acc_out;
   logic [15:0] dp_out;
   logic        fetch_blocked;
   modport device (input reg_wr, reg_addr, reg_wdata, wr_src, fetch, fetch_addr, ret, ret_addr,
                   data_pointer, acc,
                   output reg_rdata, map_boot, array_busy, svc_done, acc_out, dp_out, fetch_blocked);
   modport core (output reg_wr, reg_addr, reg_wdata, wr_src, fetch, fetch_addr, ret, ret_addr,
                 data_pointer, acc,
                 input reg_rdata, map_boot, array_busy, svc_done, acc_out, dp_out, fetch_blocked);
endinterface

// file: pkg/pfb_pkg.sv
// Package for the program memory / boot ROM control block.
// Assumes a single 250 MHz clock shared by both ends.
package pfb_pkg;
   // Control register and field layout
   localparam logic [7:0] CTRL_ADDR      = 8'hfb;
   localparam int         BIT_BSEL_HIGH  = 7;
   localparam int         BIT_BSEL_LOW   = 6;
   localparam int         BIT_HV         = 5;
   localparam int         BIT_RSVD       = 4;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   // Function codes
   localparam logic [3:0] FC_NONE        = 4'h0;
   localparam logic [3:0] FC_BYTE        = 4'h5;
   localparam logic [3:0] FC_PAGE        = 4'hc;
   localparam logic [3:0] FC_BLOCK       = 4'h3;
   localparam logic [3:0] FC_FULL        = 4'ha;
   // Array geometry
   localparam int          ARRAY_AW      = 15;
   localparam logic [14:0] SECURITY_ADDR = 15'h7fff;
   localparam logic [14:0] PAGE_MASK     = 15'h7fe0;
   localparam logic [14:0] BLOCK_MASK    = 15'h7f00;
   localparam logic [15:0] BOOT_BORDER   = 16'hfc00;
   localparam logic [7:0]  ERASED_BYTE   = 8'hff;
   // Service entry points
   localparam logic [15:0] ENTRY_READ    = 16'hffba;
   localparam logic [15:0] ENTRY_WRITE   = 16'hffad;
   localparam logic [15:0] ENTRY_PAGE    = 16'hffaa;
   localparam logic [15:0] ENTRY_BLOCK   = 16'hffa5;
   localparam logic [15:0] ENTRY_FULL    = 16'hffa0;
   localparam logic [7:0]  BLOCK_DP_LOW  = 8'h08;
   localparam logic [7:0]  FULL_DP_OUT   = 8'h18;
   // Timing: ns figures, cycles at 4 ns
   localparam int CLK_NS       = 4;
   localparam int PROG_NS      = 2500000;
   localparam int ERASE_NS     = 5000000;
   localparam int PROG_CYCLES  = PROG_NS / CLK_NS;
   localparam int ERASE_CYCLES = ERASE_NS / CLK_NS;
   localparam int RC_DIV       = 4;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01,
      ST_DONE = 2'b10
   } pfb_state_type;
   // Fetch origin of the instruction that writes the register
   typedef enum logic [1:0] {
      SRC_ARRAY = 2'b00,
      SRC_BOOT  = 2'b01,
      SRC_EXT   = 2'b10
   } pfb_src_type;
endpackage

// file: testbench/pfb_link_checker.sv
// Assertion checker for the link between the core end and the device end.
// Assumes one clock and a synchronous active-high reset; instantiated in tb.
`timescale 1ns/1ps
module pfb_link_checker
   import pfb_pkg::*;
(
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   // Link signals
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_rdata,
   input wire logic        fetch,
   input wire logic [15:0] fetch_addr,
   input wire logic        map_boot,
   input wire logic        array_busy,
   input wire logic        svc_done,
   input wire logic        fetch_blocked
);
   // Upper bound of a service with the shortened timer counts
   localparam int SVC_MAX = 64;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // Reset itself must be seen here, so no disable
   chk_reset_image: assert property (disable iff (1'b0) i_sys_rst |=> reg_rdata == CTRL_RESET)
      else $error("control image not cleared by reset");
   chk_user_map: assert property (fetch && reg_rdata[7:6] == 2'b00 |-> !map_boot)
      else $error("boot space mapped with selection 00");
   chk_split_map: assert property (fetch && reg_rdata[7:6] == 2'b01 |-> map_boot == (fetch_addr >= BOOT_BORDER))
      else $error("split map wrong for selection 01");
   chk_busy_blocks: assert property (array_busy && fetch && !map_boot |-> fetch_blocked)
      else $error("array fetch allowed while busy");
   chk_hv_flag: assert property (array_busy && $past(array_busy) |-> reg_rdata[BIT_HV])
      else $error("voltage flag low during a cycle");
   chk_done_clears: assert property (svc_done |-> ##[0:2] reg_rdata[7:6] == 2'b00)
      else $error("selection not cleared on return");
   chk_busy_bounded: assert property ($rose(array_busy) |-> ##[1:SVC_MAX] svc_done)
      else $error("service never completed");
   chk_busy_ignore: assert property (array_busy && reg_wr |=> reg_rdata[3:0] == $past(reg_rdata[3:0]))
      else $error("function code changed while busy");

   // Main scenarios reached
   cover property ($rose(array_busy));
   cover property (svc_done);
   cover property (fetch && map_boot);
endmodule // pfb_link_checker

// file: testbench/tb.sv
// Self-checking bench: both ends joined by the link, Avalon stimulus.
// Assumes sim timer counts of 20 and 40 cycles.
`timescale 1ns/1ps
module tb;
   import pfb_pkg::*;
   localparam int PROG  = 20;
   localparam int ERASE = 40;
   logic        clk     = 1'b0;
   logic        rst     = 1'b1;
   logic        fs_n    = 1'b1;
   logic        ea_n    = 1'b1;
   logic        ale     = 1'b1;
   logic [3:0]  av_addr = 4'h0;
   logic        av_rd   = 1'b0;
   logic        av_wr   = 1'b0;
   logic [31:0] av_wd   = 32'h0;
   logic [7:0]  arr_rd  = 8'h00;
   wire  [31:0] av_q;
   wire         av_wait;
   wire  [14:0] arr_addr, er_base, er_mask;
   wire  [7:0]  arr_wd;
   wire         arr_wr, arr_er, boot_st, int_st;
   logic [14:0] m_addr, m_base, m_mask;
   logic [7:0]  m_data;
   int          m_wr_cnt = 0;
   int          busy_len = 0;
   int          fails = 0;
   int          checks_done = 0;
   int          seed = 60;
   logic [7:0]  op_ctl [4] = '{8'h45, 8'h4c, 8'h43, 8'h4a};
   logic [15:0] op_entry [4] = '{ENTRY_WRITE, ENTRY_PAGE, ENTRY_BLOCK, ENTRY_FULL};

   always #2 clk = ~clk;

   pfb_if link();
   pfb_core_end i_pfb_core_end (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
      .i_avs_write(av_wr), .i_avs_writedata(av_wd), .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait), .bus(link));
   pfb_device #(.PROG_CNT(PROG), .ERASE_CNT(ERASE)) i_pfb_device (.i_clk(clk), .i_sys_rst(rst),
      .i_fetch_strobe_pin_n(fs_n), .i_external_access_pin_n(ea_n), .i_addr_latch_pin(ale), .bus(link),
      .o_array_addr(arr_addr), .o_array_wdata(arr_wd), .o_array_wr(arr_wr), .o_erase_base(er_base),
      .o_erase_mask(er_mask), .o_array_erase(arr_er), .i_array_rdata(arr_rd), .o_boot_start(boot_st),
      .o_internal_start(int_st));
   pfb_link_checker i_pfb_link_checker (.i_clk(clk), .i_sys_rst(rst), .reg_wr(link.reg_wr),
      .reg_rdata(link.reg_rdata), .fetch(link.fetch), .fetch_addr(link.fetch_addr), .map_boot(link.map_boot),
      .array_busy(link.array_busy), .svc_done(link.svc_done), .fetch_blocked(link.fetch_blocked));

   // Array port monitor; busy time accumulates, callers take differences
   always @(posedge clk) begin
      if (arr_wr === 1'b1) begin
         m_addr <= arr_addr;
         m_data <= arr_wd;
         m_wr_cnt <= m_wr_cnt + 1;
      end
      if (arr_er === 1'b1) begin
         m_base <= er_base;
         m_mask <= er_mask;
      end
      if (link.array_busy === 1'b1) busy_len <= busy_len + 1;
   end

   task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One Avalon access; held until the edge that sees waitrequest low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      av_addr <= a;
      av_wd <= d;
      av_wr <= wr;
      av_rd <= !wr;
      @(posedge clk);
      while (av_wait !== 1'b0 && n < 5000) begin
         n++;
         @(posedge clk);
      end
      if (n >= 5000) begin
         cmp("waitrequest", 16'h0, 16'h1);
         test_done;
      end
      // Read data taken at the accept edge, then released
      q = av_q;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic do_reset(input logic f, input logic e, input logic l);
      fs_n <= f;
      ea_n <= e;
      ale <= l;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   function automatic logic [15:0] exp_dp(input logic [3:0] c, input logic [15:0] d);
      case (c)
         FC_PAGE:  return d & 16'hffe0;
         FC_BLOCK: return {d[15:8], BLOCK_DP_LOW};
         FC_FULL:  return {8'h00, FULL_DP_OUT};
         default:  return d;
      endcase
   endfunction

   function automatic logic [7:0] exp_acc(input logic [3:0] c, input logic [7:0] a);
      case (c)
         FC_PAGE:  return 8'h08;
         FC_BLOCK: return 8'h02;
         FC_FULL:  return 8'h0a;
         default:  return a;
      endcase
   endfunction

   // Full service call through the boot entry, then results and array port
   task automatic run_op(input int k);
      logic [31:0] q;
      logic [15:0] dp;
      logic [7:0]  acc;
      logic [3:0]  c;
      logic [14:0] msk;
      int          b0, n, lim;
      c = op_ctl[k][3:0];
      dp = 16'($random(seed)) & 16'h7fff;
      acc = 8'($random(seed));
      lim = (c == FC_BYTE) ? PROG : ERASE;
      msk = (c == FC_PAGE) ? PAGE_MASK : (c == FC_BLOCK) ? BLOCK_MASK : 15'h0000;
      av(1'b1, 4'h0, {24'h0, op_ctl[k]}, q);
      av(1'b1, 4'h1, {acc, 8'h00, dp}, q);
      arr_rd <= acc;
      b0 = busy_len;
      av(1'b1, 4'h2, {16'h0, op_entry[k]}, q);
      n = 0;
      q = 32'h0;
      while (q[24] !== 1'b1 && n < 100) begin
         av(1'b0, 4'h3, 32'h0, q);
         n++;
      end
      cmp("done", 16'h1, 16'(q[24]));
      cmp("dp out", exp_dp(c, dp), q[15:0]);
      cmp("acc out", 16'(exp_acc(c, acc)), 16'(q[23:16]));
      cmp("busy span", 16'h1, 16'((busy_len - b0 >= lim) && (busy_len - b0 <= lim + 3)));
      av(1'b0, 4'h0, 32'h0, q);
      cmp("ctrl after", 16'(c), 16'(q[7:0] & 8'hef));
      if (c == FC_BYTE) begin
         cmp("write addr", 16'(dp[14:0]), 16'(m_addr));
         cmp("write data", 16'(acc), 16'(m_data));
      end else begin
         cmp("erase mask", 16'(msk), 16'(m_mask));
         cmp("erase base", 16'(dp[14:0] & msk), 16'(m_base & m_mask));
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      logic [31:0] q;
      logic [7:0]  w;
      int          b;
      do_reset(1'b1, 1'b1, 1'b1);
      av(1'b0, 4'h0, 32'h0, q);
      cmp("ctrl reset", 16'(CTRL_RESET), 16'(q[7:0]));
      cmp("internal start", 16'h1, 16'(int_st));
      cmp("boot start", 16'h0, 16'(boot_st));
      // Voltage flag must ignore writes; reserved bit kept zero
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 8'h20 : 8'($random(seed)) & 8'h6f;
         av(1'b1, 4'h0, {24'h0, w}, q);
         av(1'b0, 4'h0, 32'h0, q);
         cmp("ctrl readback", 16'(w & 8'h4f), 16'(q[7:0]));
      end
      for (int r = 0; r < 2; r++)
         for (int k = 0; k < 4; k++) run_op(k);
      // Call with user mapping: no array activity allowed
      b = m_wr_cnt;
      av(1'b1, 4'h0, 32'h05, q);
      av(1'b1, 4'h2, {16'h0, ENTRY_WRITE}, q);
      repeat (PROG * 2) @(posedge clk);
      cmp("no write outside boot", 16'(b), 16'(m_wr_cnt));
      av(1'b0, 4'h0, 32'h0, q);
      cmp("ctrl no call", 16'h05, 16'(q[7:0]));
      do_reset(1'b0, 1'b0, 1'b1);
      cmp("strap boot", 16'h1, 16'(boot_st));
      do_reset(1'b1, 1'b0, 1'b1);
      cmp("external start", 16'h0, 16'(int_st));
      test_done;
   end

   // Watchdog sized well above the expected run
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("MISMATCH watchdog expected finish seen timeout");
      test_done;
   end
endmodule // tb
